// file: bdc_defs.vh
// Constants of the buffer RAM DMA function-call block
// Assumes an APB slave on pclk and a word memory port with ack and error
`ifndef BDC_DEFS_VH
`define BDC_DEFS_VH

// Register byte offsets
`define BDC_OFS_CMD      8'h00
`define BDC_OFS_SRC      8'h04
`define BDC_OFS_DST      8'h08
`define BDC_OFS_SIZE     8'h0C
`define BDC_OFS_SPARE    8'h10
`define BDC_OFS_RESULT   8'h14
`define BDC_OFS_EXCADDR  8'h18
`define BDC_OFS_INTSTAT  8'h1C
`define BDC_OFS_INTMASK  8'h20

// Command codes
`define BDC_CMD_XFER     16'h5211
`define BDC_CMD_FILL     16'h5212
`define BDC_CMD_B2B      16'h5104

// Result word fields
`define BDC_RES_OK       2'h0
`define BDC_RES_INVALID  2'h1
`define BDC_RES_EXCEPT   2'h2
`define BDC_DONE_BIT     29

// Interrupt status bits
`define BDC_INT_B2B_DONE 0
`define BDC_INT_B2B_EXC  1

// Fill minimum word count
`define BDC_FILL_MIN     32'h00000004

// Reset values
`define BDC_RST_WORD     32'h00000000

`endif

// file: bdc_dma.v
// Buffer RAM DMA engine driven by hardware function calls over APB
// Assumes one clock, a memory port that holds ack or err one cycle per request
//
// Chosen here: the address map and register access over APB.
`include "bdc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module bdc_dma #(
   parameter [31:0] BUF_BASE = 32'h20000000,
   parameter [31:0] BUF_SIZE = 32'h00100000
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Memory master port
   output reg         mem_req,
   output reg         mem_we,
   output reg  [31:0] mem_addr,
   output reg  [31:0] mem_wdata,
   input  wire [31:0] mem_rdata,
   input  wire        mem_ack,
   input  wire        mem_err,
   // Interrupt
   output reg         irq
);

   // ****************************************************************
   // States and operation kinds
   // ****************************************************************
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_RD   = 2'h1;
   localparam [1:0] ST_WR   = 2'h2;

   localparam [1:0] OP_XFER = 2'h0;
   localparam [1:0] OP_FILL = 2'h1;
   localparam [1:0] OP_B2B  = 2'h2;

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [31:0] src_reg;
   reg [31:0] dst_reg;
   reg [31:0] size_reg;
   reg [1:0]  res_code_reg;
   reg        done_reg;
   reg [31:0] exc_addr_reg;
   reg [1:0]  int_stat_reg;
   reg [1:0]  int_mask_reg;
   reg [1:0]  state_reg;
   reg [1:0]  op_reg;
   reg [31:0] cur_src_reg;
   reg [31:0] cur_dst_reg;
   reg [31:0] words_reg;

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire        acc      = psel & penable & ~pready;
   wire        wr_acc   = acc & pwrite;
   wire        busy     = (state_reg != ST_IDLE);
   wire        src_buf  = (src_reg >= BUF_BASE) && (src_reg - BUF_BASE < BUF_SIZE);
   wire        dst_buf  = (dst_reg >= BUF_BASE) && (dst_reg - BUF_BASE < BUF_SIZE);
   wire [31:0] xfer_wds = {2'h0, size_reg[31:2]} + {31'h0, |size_reg[1:0]};
   wire [31:0] b2b_wds  = {16'h0, 2'h0, size_reg[15:2]} + {31'h0, |size_reg[1:0]};
   wire [31:0] res_word = {2'h0, done_reg, 27'h0, res_code_reg};
   wire        mapped   = (paddr == `BDC_OFS_CMD)     || (paddr == `BDC_OFS_SRC)    ||
                          (paddr == `BDC_OFS_DST)     || (paddr == `BDC_OFS_SIZE)   ||
                          (paddr == `BDC_OFS_SPARE)   || (paddr == `BDC_OFS_RESULT) ||
                          (paddr == `BDC_OFS_EXCADDR) || (paddr == `BDC_OFS_INTSTAT)||
                          (paddr == `BDC_OFS_INTMASK);
   wire        cmd_wr   = wr_acc && (paddr == `BDC_OFS_CMD) && !busy;
   wire        cmd_busy = wr_acc && (paddr == `BDC_OFS_CMD) && busy;
   wire        arg_wr   = wr_acc && !busy;
   wire        last_wd  = (words_reg == 32'h00000001);
   wire        wr_end   = (state_reg == ST_WR) && mem_ack && last_wd;
   wire        mem_fail = mem_req && mem_err;

   reg [31:0] rd_mux;
   always @* begin
      if (paddr == `BDC_OFS_SRC) begin
         rd_mux = src_reg;
      end else if (paddr == `BDC_OFS_DST) begin
         rd_mux = dst_reg;
      end else if (paddr == `BDC_OFS_SIZE) begin
         rd_mux = size_reg;
      end else if (paddr == `BDC_OFS_RESULT) begin
         rd_mux = res_word;
      end else if (paddr == `BDC_OFS_EXCADDR) begin
         rd_mux = exc_addr_reg;
      end else if (paddr == `BDC_OFS_INTSTAT) begin
         rd_mux = {30'h0, int_stat_reg};
      end else if (paddr == `BDC_OFS_INTMASK) begin
         rd_mux = {30'h0, int_mask_reg};
      end else begin
         rd_mux = `BDC_RST_WORD;
      end
   end

   // ****************************************************************
   // APB answer, one wait state
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `BDC_RST_WORD;
      end else begin
         pready  <= acc;
         pslverr <= acc & (~mapped | cmd_busy);
         prdata  <= (acc & ~pwrite) ? rd_mux : `BDC_RST_WORD;
      end
   end

   // ****************************************************************
   // Argument registers
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_reg      <= `BDC_RST_WORD;
         dst_reg      <= `BDC_RST_WORD;
         size_reg     <= `BDC_RST_WORD;
         int_mask_reg <= 2'h0;
      end else begin
         if (arg_wr && paddr == `BDC_OFS_SRC) begin
            src_reg <= pwdata;
         end
         if (arg_wr && paddr == `BDC_OFS_DST) begin
            dst_reg <= pwdata;
         end
         if (arg_wr && paddr == `BDC_OFS_SIZE) begin
            size_reg <= pwdata;
         end
         if (wr_acc && paddr == `BDC_OFS_INTMASK) begin
            int_mask_reg <= pwdata[1:0];
         end
      end
   end

   // ****************************************************************
   // Interrupt status, set wins over write-one-clear
   // ****************************************************************
   wire       stat_clr = wr_acc && (paddr == `BDC_OFS_INTSTAT);
   wire [1:0] stat_set;
   assign stat_set[`BDC_INT_B2B_DONE] = (op_reg == OP_B2B) && wr_end;
   assign stat_set[`BDC_INT_B2B_EXC]  = (op_reg == OP_B2B) && mem_fail;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_reg <= 2'h0;
         irq          <= 1'b0;
      end else begin
         int_stat_reg <= (int_stat_reg & ~(stat_clr ? pwdata[1:0] : 2'h0)) | stat_set;
         irq          <= |(int_stat_reg & int_mask_reg);
      end
   end

   // ****************************************************************
   // Call engine
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg    <= ST_IDLE;
         op_reg       <= OP_XFER;
         res_code_reg <= `BDC_RES_OK;
         done_reg     <= 1'b0;
         exc_addr_reg <= `BDC_RST_WORD;
         cur_src_reg  <= `BDC_RST_WORD;
         cur_dst_reg  <= `BDC_RST_WORD;
         words_reg    <= `BDC_RST_WORD;
         mem_req      <= 1'b0;
         mem_we       <= 1'b0;
         mem_addr     <= `BDC_RST_WORD;
         mem_wdata    <= `BDC_RST_WORD;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (cmd_wr) begin
                  exc_addr_reg <= `BDC_RST_WORD;
                  res_code_reg <= `BDC_RES_OK;
                  cur_src_reg  <= src_reg;
                  cur_dst_reg  <= dst_reg;
                  if (pwdata[15:0] == `BDC_CMD_XFER) begin
                     op_reg <= OP_XFER;
                     if (src_buf && dst_buf) begin
                        res_code_reg <= `BDC_RES_INVALID;
                        done_reg     <= 1'b1;
                     end else if (xfer_wds == `BDC_RST_WORD) begin
                        done_reg <= 1'b1;
                     end else begin
                        done_reg  <= 1'b0;
                        words_reg <= xfer_wds;
                        state_reg <= ST_RD;
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b0;
                        mem_addr  <= src_reg;
                     end
                  end else if (pwdata[15:0] == `BDC_CMD_FILL) begin
                     op_reg <= OP_FILL;
                     if (dst_reg[1:0] != 2'h0 || size_reg < `BDC_FILL_MIN) begin
                        res_code_reg <= `BDC_RES_INVALID;
                        done_reg     <= 1'b1;
                     end else begin
                        done_reg  <= 1'b0;
                        words_reg <= size_reg;
                        state_reg <= ST_WR;
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= dst_reg;
                        mem_wdata <= src_reg;
                     end
                  end else if (pwdata[15:0] == `BDC_CMD_B2B) begin
                     op_reg   <= OP_B2B;
                     done_reg <= 1'b1;
                     if (!(src_buf && dst_buf)) begin
                        res_code_reg <= `BDC_RES_INVALID;
                     end else if (b2b_wds != `BDC_RST_WORD) begin
                        words_reg <= b2b_wds;
                        state_reg <= ST_RD;
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b0;
                        mem_addr  <= src_reg;
                     end
                  end else begin
                     res_code_reg <= `BDC_RES_INVALID;
                     done_reg     <= 1'b1;
                  end
               end
            end
            ST_RD: begin
               if (mem_err) begin
                  mem_req   <= 1'b0;
                  state_reg <= ST_IDLE;
                  if (op_reg != OP_B2B) begin
                     res_code_reg <= `BDC_RES_EXCEPT;
                     exc_addr_reg <= mem_addr;
                     done_reg     <= 1'b1;
                  end
               end else if (mem_ack) begin
                  state_reg   <= ST_WR;
                  mem_we      <= 1'b1;
                  mem_addr    <= cur_dst_reg;
                  mem_wdata   <= mem_rdata;
                  cur_src_reg <= cur_src_reg + 32'h00000004;
               end
            end
            ST_WR: begin
               if (mem_err) begin
                  mem_req   <= 1'b0;
                  mem_we    <= 1'b0;
                  state_reg <= ST_IDLE;
                  if (op_reg != OP_B2B) begin
                     res_code_reg <= `BDC_RES_EXCEPT;
                     exc_addr_reg <= mem_addr;
                     done_reg     <= 1'b1;
                  end
               end else if (mem_ack) begin
                  words_reg   <= words_reg - 32'h00000001;
                  cur_dst_reg <= cur_dst_reg + 32'h00000004;
                  if (last_wd) begin
                     mem_req   <= 1'b0;
                     mem_we    <= 1'b0;
                     state_reg <= ST_IDLE;
                     done_reg  <= 1'b1;
                  end else if (op_reg == OP_FILL) begin
                     mem_addr <= mem_addr + 32'h00000004;
                  end else begin
                     state_reg <= ST_RD;
                     mem_we    <= 1'b0;
                     mem_addr  <= cur_src_reg;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // bdc_dma

`default_nettype wire

// file: bdc_dma_assertions.sv
// Port assertions for the function-call DMA block
// Assumes the bind at the foot reaches every bdc_dma instance
`include "bdc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module bdc_dma_assertions (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Memory side and interrupt
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic        mem_ack,
   input wire logic        mem_err,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic rd_ok = pready && !pwrite && !pslverr;
   wire logic hold  = mem_req && !mem_ack && !mem_err;
   wire logic cmd_w = pready && pwrite && !pslverr && paddr == `BDC_OFS_CMD;
   wire logic known = pwdata[15:0] == `BDC_CMD_XFER || pwdata[15:0] == `BDC_CMD_FILL
                      || pwdata[15:0] == `BDC_CMD_B2B;
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_slverr_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_unmapped_refused: assert property (psel && penable && pready && paddr > 8'h20 |-> pslverr)
      else $error("unmapped access not refused");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
      else $error("read data outside answer cycle");
   a_req_held: assert property (hold |=> mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request dropped or changed before answer");
   a_wdata_held: assert property (hold && mem_we |=> $stable(mem_wdata))
      else $error("memory write data changed before answer");
   a_result_zeros: assert property (rd_ok && paddr == `BDC_OFS_RESULT |->
      prdata[31:30] == 2'h0 && prdata[28:2] == 27'h0000000)
      else $error("unused result bits not zero");
   a_spare_zero: assert property (rd_ok && paddr == `BDC_OFS_SPARE |-> prdata == 32'h00000000)
      else $error("spare argument not zero");
   a_unknown_idle: assert property (cmd_w && !known |-> !mem_req)
      else $error("unknown command started memory traffic");
   c_mem_err: cover property (mem_err);
   c_copy_call: cover property (cmd_w && pwdata[15:0] == `BDC_CMD_B2B);
   c_irq: cover property ($rose(irq));
endmodule // bdc_dma_assertions
bind bdc_dma bdc_dma_assertions bdc_dma_assertions_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err),
   .irq(irq));
`default_nettype wire

// file: bdc_mem_model.sv
// Word memory answering the block's memory port
// Assumes addresses below 0x80 in data RAM and in buffer RAM
`timescale 1ns/1ps
`default_nettype none
module bdc_mem_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Memory port
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output var  logic [31:0] mem_rdata,
   output var  logic        mem_ack,
   output var  logic        mem_err,
   // Wait states and failing address
   input  wire logic [1:0]  delay,
   input  wire logic [31:0] err_addr
);
   logic [31:0] mem [0:63];
   logic [1:0]  cnt;
   wire  [5:0]  idx = {mem_addr[29], mem_addr[6:2]};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 2'h0;
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= 32'h00000000;
      end else begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack && !mem_err) begin
            cnt <= cnt == delay ? 2'h0 : cnt + 2'h1;
            if (cnt == delay && mem_addr == err_addr) mem_err <= 1'b1;
            else if (cnt == delay) begin
               mem_ack <= 1'b1;
               if (mem_we) mem[idx] <= mem_wdata;
               else mem_rdata <= mem[idx];
            end
         end
      end
   end
endmodule // bdc_mem_model
`default_nettype wire

// file: buffer_ram_dma_function_calls_tb_top.sv
// Self-checking bench for the function-call DMA block
// Assumes the block, the memory model and the checker are compiled first
`include "bdc_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module buffer_ram_dma_function_calls_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
   logic        mem_req, mem_we, mem_ack, mem_err;
   logic [7:0]  paddr;
   logic [1:0]  delay;
   logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, err_addr, r;
   int          n_errors, n_compared, n;
   bdc_dma bdc_dma_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
      .irq(irq));
   bdc_mem_model bdc_mem_model_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .mem_err(mem_err), .delay(delay), .err_addr(err_addr));
   task automatic report_and_stop;
      if (n_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) n_errors++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic call(input logic [31:0] c, input logic [31:0] s, d, z);
      apb(1'b1, `BDC_OFS_SRC, s);
      apb(1'b1, `BDC_OFS_DST, d);
      apb(1'b1, `BDC_OFS_SIZE, z);
      apb(1'b1, `BDC_OFS_CMD, c);
   endtask
   task automatic wait_done;
      r = 32'h00000000;
      for (int k = 0; k < 60 && r[29] !== 1'b1; k++) apb(1'b0, `BDC_OFS_RESULT, 32'h0);
   endtask
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      report_and_stop;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      delay = 2'h2;
      err_addr = 32'hFFFFFFFF;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `BDC_OFS_RESULT, 32'h0);
      chk("result_reset", 32'h00000000, r);
      apb(1'b1, `BDC_OFS_SRC, 32'hCAFE0001);
      apb(1'b0, `BDC_OFS_SRC, 32'h0);
      chk("src_rw", 32'hCAFE0001, r);
      call(`BDC_CMD_FILL, 32'hA5A50F0F, 32'h40, 32'h4);
      apb(1'b1, `BDC_OFS_CMD, `BDC_CMD_FILL);
      chk("busy_refused", 32'h1, e);
      apb(1'b0, `BDC_OFS_RESULT, 32'h0);
      chk("fill_pending", 32'h0, r[29]);
      wait_done;
      chk("fill_result", 32'h20000000, r);
      for (int k = 0; k < 4; k++) chk("fill_word", 32'hA5A50F0F, bdc_mem_model_i.mem[16+k]);
      apb(1'b0, `BDC_OFS_EXCADDR, 32'h0);
      chk("excaddr_clear", 32'h0, r);
      for (int i = 0; i < 3; i++) begin
         call(i == 2 ? 32'h1234 : `BDC_CMD_FILL, 32'h0, i == 0 ? 32'h41 : 32'h40, 4 - (i % 2));
         wait_done;
         chk("invalid_call", 32'h20000001, r);
      end
      delay <= 2'h0;
      for (int k = 0; k < 4; k++) bdc_mem_model_i.mem[16+k] = 32'h11111111 * (k + 1);
      for (int j = 0; j < 2; j++) begin
         call(`BDC_CMD_XFER, 32'h40, j ? 32'h60 : 32'h20000000, 32'd13);
         wait_done;
         chk("xfer_result", 32'h20000000, r);
         for (int k = 0; k < 4; k++)
            chk("xfer_word", 32'h11111111 * (k + 1), bdc_mem_model_i.mem[(j ? 24 : 32)+k]);
      end
      call(`BDC_CMD_XFER, 32'h20000000, 32'h20000040, 32'h8);
      wait_done;
      chk("xfer_b2b", 32'h20000001, r);
      err_addr <= 32'h48;
      call(`BDC_CMD_XFER, 32'h40, 32'h20000000, 32'h10);
      wait_done;
      chk("xfer_error", 32'h20000002, r);
      apb(1'b0, `BDC_OFS_EXCADDR, 32'h0);
      chk("excaddr", 32'h48, r);
      err_addr <= 32'hFFFFFFFF;
      apb(1'b1, `BDC_OFS_INTMASK, 32'h1);
      bdc_mem_model_i.mem[50] = 32'h5A5A5A5A;
      call(`BDC_CMD_B2B, 32'h20000000, 32'h20000040, 32'h00010008);
      apb(1'b0, `BDC_OFS_RESULT, 32'h0);
      chk("copy_accept", 32'h20000000, r);
      for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge pclk);
      chk("copy_irq", 32'h1, irq);
      chk("copy_word0", 32'h11111111, bdc_mem_model_i.mem[48]);
      chk("copy_word1", 32'h22222222, bdc_mem_model_i.mem[49]);
      chk("copy_word2", 32'h5A5A5A5A, bdc_mem_model_i.mem[50]);
      apb(1'b1, `BDC_OFS_INTSTAT, 32'h1);
      apb(1'b0, `BDC_OFS_INTSTAT, 32'h0);
      chk("intstat_clear", 32'h0, r);
      chk("irq_clear", 32'h0, irq);
      apb(1'b1, `BDC_OFS_INTMASK, 32'h0);
      err_addr <= 32'h20000000;
      call(`BDC_CMD_B2B, 32'h20000000, 32'h20000040, 32'h8);
      for (int k = 0; k < 30 && r[1] !== 1'b1; k++) apb(1'b0, `BDC_OFS_INTSTAT, 32'h0);
      chk("copy_exception", 32'h1, r[1]);
      chk("irq_masked", 32'h0, irq);
      apb(1'b0, `BDC_OFS_RESULT, 32'h0);
      chk("copy_err_result", 32'h20000000, r);
      apb(1'b1, `BDC_OFS_INTMASK, 32'h2);
      apb(1'b0, `BDC_OFS_SPARE, 32'h0);
      chk("irq_unmasked", 32'h1, irq);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 32'h1, e);
      chk("unmapped_data", 32'h0, r);
      report_and_stop;
   end
endmodule // buffer_ram_dma_function_calls_tb_top
`default_nettype wire
